/* File: rtl/lps_pkg.sv */
package lps_pkg;

   // Clock period of ref_clk in nanoseconds.
   localparam int CLK_PERIOD_NS = 100;

   // Timing figures in nanoseconds; CKE_MIN_CYC, SR_RES_CYC, XS_CYC, XP_CYC, XPDLL_CYC and REF_INT_CYC derive from them.
   localparam int CKE_MIN_PULSE_NS = 5000;
   localparam int MIN_SR_RESIDENCY_NS = 5000;
   localparam int EXIT_NON_DLL_NS = 1700;
   localparam int PD_EXIT_NS = 2400;
   localparam int PD_EXIT_DLL_NS = 2400;
   localparam int INT_REFRESH_NS = 1700;

   // Least times round up to whole cycles, never below one.
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CKE_MIN_CYC = ns_to_cyc(CKE_MIN_PULSE_NS);
   localparam int SR_RES_CYC = ns_to_cyc(MIN_SR_RESIDENCY_NS);
   localparam int XS_CYC = ns_to_cyc(EXIT_NON_DLL_NS);
   localparam int XSDLL_CYC = 512;
   localparam int XP_CYC = ns_to_cyc(PD_EXIT_NS);
   localparam int XPDLL_CYC = ns_to_cyc(PD_EXIT_DLL_NS);
   localparam int REF_INT_CYC = ns_to_cyc(INT_REFRESH_NS);
   localparam int CPDED_CYC = 1;
   localparam int VREF_FLOAT_CYC = 512;
   localparam int ODT_LEAD_CYC = 8;
   localparam int AREFI_CYC = 78;
   localparam int PD_MAX_REFI = 9;
   localparam int CNT_W = 16;

   // Command encodings on {cs_n, ras_n, cas_n, we_n}.
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_PRE = 4'h2;

   // Device power states, Gray coded from idle into self-refresh and on to its exit state, between idle and precharge power-down, and from reset to idle.
   typedef enum logic [2:0] {
      LPS_IDLE = 3'h0,
      LPS_SELF_REFRESH = 3'h1,
      LPS_SR_EXIT = 3'h3,
      LPS_PD_PRECHARGE = 3'h2,
      LPS_PD_ACTIVE = 3'h6,
      LPS_RESET = 3'h4
   } lps_state_t;

   // Decodes a no-operation or a deselect.
   function automatic logic is_nop_or_des(input logic [3:0] cmd);
      return cmd[3] || (cmd == CMD_NOP);
   endfunction

endpackage

/* File: rtl/lps_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Pins between the memory controller and the low-power logic.
interface lps_link_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic reset_n;

   // The controller drives every pin.
   modport ctrl
   (
      output cke, cs_n, ras_n, cas_n, we_n, odt, reset_n
   );

   // The device only samples.
   modport dev
   (
      input cke, cs_n, ras_n, cas_n, we_n, odt, reset_n
   );
endinterface

`default_nettype wire

/* File: rtl/lps_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Down counter: load starts a wait, done is high once it has run out.
module lps_delay_timer
#(
   parameter int W = 16
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] count;

   // Count is held at zero when idle, so done reads high after reset.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         count <= '0;
      end
      else if (load)
      begin
         count <= value;
      end
      else if (count != '0)
      begin
         count <= count - 1'b1;
      end
   end

   assign done = (count == '0) && !load;
endmodule

`default_nettype wire

/* File: rtl/lps_device.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Decode self-refresh entry from command and CKE
// - Entry only from idle, all banks closed
// - Termination off before self-refresh entry
// - CKE held low throughout self-refresh
// - DLL off in self-refresh, reset on exit
// - Ignore inputs but CKE, reset; clock gated
// - No write for 512 cycles after self-refresh exit with floated reference
// - Internal timer refreshes within CKE pulse period
// - Stay in self-refresh the minimum residency
// - Clock stable before raising CKE to exit
// - Only NOP until non-DLL exit delay
// - Locked-DLL commands wait the DLL exit delay
// - CKE high, termination off during exit delay
// - Extra refresh before re-entering self-refresh
// - Power-down entry: CKE low with NOP
// - Precharge or active power-down by bank state
// - Buffers off on entry, receivers off after blank period
// - DLL off in power-down only for slow-exit precharge
// - Slow exit waits DLL latency for reads
// - Unlocked DLL needs reset after power-down exit; none is issued, the controller only waits XSDLL cycles
// - Power-down limits; reset pin forces reset
// - Power-down exit: CKE high with NOP
module lps_device
import lps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   lps_link_if.dev link,
   input wire logic any_bank_open,
   input wire logic dll_disable_bit,
   input wire logic slow_fast_exit_select_bit,
   output logic [2:0] power_state,
   output logic dll_enabled,
   output logic dll_reset_pulse,
   output logic internal_clk_on,
   output logic input_buffers_on,
   output logic cmd_receivers_on,
   output logic internal_refresh_pulse
);
   import lps_pkg::*;

   lps_state_t state;
   lps_state_t next_state;
   logic [3:0] cmd;
   logic cke_prev;
   logic [CNT_W-1:0] ref_cnt;
   logic blank_load; // Starts the blanking wait on power-down entry.
   logic blank_done; // High once the blanking wait has run out.
   logic sre_hit;
   logic pde_hit;
   logic exit_hit;
   logic slow_pd;

   // Command word sampled on every rising edge.
   assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

   // Self-refresh entry: REF encoding with CKE falling.
   assign sre_hit = cke_prev && !link.cke && (cmd == CMD_REF);
   // Power-down entry: CKE falling with NOP or deselect.
   assign pde_hit = cke_prev && !link.cke && is_nop_or_des(cmd);
   // Power-down exit: CKE high with NOP or deselect.
   assign exit_hit = link.cke && is_nop_or_des(cmd);
   // Slow exit when bit clear; bank state is checked where slow_pd is used.
   assign slow_pd = !slow_fast_exit_select_bit;
   // The blanking wait starts on the edge that leaves idle for power-down.
   assign blank_load = (state == LPS_IDLE)
      && (next_state == LPS_PD_ACTIVE || next_state == LPS_PD_PRECHARGE);

   // Times the command blanking period after CKE falls.
   lps_delay_timer #(.W(CNT_W)) lps_delay_timer_inst
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(blank_load),
      .value(CNT_W'(CPDED_CYC)),
      .done(blank_done)
   );

   // Next power state; only CKE and reset matter inside self-refresh.
   always_comb
   begin
      next_state = state;
      case (state)
         LPS_IDLE:
         begin
            if (sre_hit)
            begin
               next_state = LPS_SELF_REFRESH;
            end
            else if (pde_hit)
            begin
               // Bank state picks the flavour of power-down.
               next_state = any_bank_open ? LPS_PD_ACTIVE : LPS_PD_PRECHARGE;
            end
         end
         LPS_SELF_REFRESH:
         begin
            // Command pins are ignored here, a CKE rise alone exits.
            if (link.cke)
            begin
               next_state = LPS_SR_EXIT;
            end
         end
         LPS_SR_EXIT:
         begin
            // Exit delay is enforced by the controller; one cycle here.
            next_state = LPS_IDLE;
         end
         LPS_PD_PRECHARGE, LPS_PD_ACTIVE:
         begin
            if (exit_hit)
            begin
               next_state = LPS_IDLE;
            end
         end
         LPS_RESET:
         begin
            next_state = LPS_IDLE;
         end
         default:
         begin
            next_state = LPS_IDLE;
         end
      endcase
      // A low reset pin overrides every state.
      if (!link.reset_n)
      begin
         next_state = LPS_RESET;
      end
   end

   // State and CKE history.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= LPS_RESET;
         cke_prev <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cke_prev <= link.cke;
      end
   end

   // Internal refresh timer fires on entry, then every interval.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ref_cnt <= '0;
         internal_refresh_pulse <= 1'b0;
      end
      else if (state == LPS_SELF_REFRESH)
      begin
         // First refresh lands well inside the minimum CKE pulse.
         internal_refresh_pulse <= (ref_cnt == '0);
         ref_cnt <= (ref_cnt == CNT_W'(REF_INT_CYC - 1)) ? '0 : ref_cnt + 1'b1;
      end
      else
      begin
         ref_cnt <= '0;
         internal_refresh_pulse <= 1'b0;
      end
   end

   // Receivers stay on through the blanking period after CKE falls.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cmd_receivers_on <= 1'b1;
      end
      else if (next_state == LPS_PD_ACTIVE || next_state == LPS_PD_PRECHARGE)
      begin
         // Once off, the receivers stay off until power-down ends.
         cmd_receivers_on <= cmd_receivers_on && !blank_done;
      end
      else
      begin
         cmd_receivers_on <= (next_state != LPS_SELF_REFRESH);
      end
   end

   // Registered status outputs.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         power_state <= LPS_RESET;
         dll_enabled <= 1'b0;
         dll_reset_pulse <= 1'b0;
         internal_clk_on <= 1'b0;
         input_buffers_on <= 1'b0;
      end
      else
      begin
         power_state <= next_state;
         // Clock gated inside self-refresh only.
         internal_clk_on <= (next_state != LPS_SELF_REFRESH);
         input_buffers_on <= (next_state == LPS_IDLE) || (next_state == LPS_SR_EXIT);
         // DLL off in self-refresh and slow-exit precharge power-down.
         dll_enabled <= !dll_disable_bit && (next_state != LPS_SELF_REFRESH)
            && (next_state != LPS_RESET)
            && !(next_state == LPS_PD_PRECHARGE && slow_pd);
         // Leaving self-refresh with the DLL in use forces a DLL reset.
         dll_reset_pulse <= (next_state == LPS_SR_EXIT) && !dll_disable_bit;
      end
   end
endmodule

`default_nettype wire

/* File: rtl/lps_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// Controller end: runs low-power requests and keeps every wait.
module lps_controller
import lps_pkg::*;
#(
   parameter int XSDLL = XSDLL_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   lps_link_if.ctrl link,
   input wire logic sr_req,
   input wire logic pd_req,
   input wire logic wake_req,
   input wire logic banks_idle,
   input wire logic vref_floated,
   input wire logic dll_was_unlocked,
   output logic busy,
   output logic nondll_ok,
   output logic locked_ok,
   output logic write_ok
);
   import lps_pkg::*;

   typedef enum logic [2:0] {
      LPC_RUN = 3'h0, LPC_ODT_OFF = 3'h1, LPC_IN_SR = 3'h3,
      LPC_IN_PD = 3'h2, LPC_EXIT = 3'h6, LPC_REF = 3'h7
   } lpc_state_t;

   lpc_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] since_exit;
   logic need_ref;
   logic from_sr; // Last exit was from self-refresh.
   logic [CNT_W-1:0] lock_wait; // Cycles before locked-DLL commands.
   logic write_wait_done; // The write hold-off after exit is over.

   // Power-down exit waits the DLL exit latency; self-refresh or an unlocked DLL relocks.
   assign lock_wait = (from_sr || dll_was_unlocked) ? CNT_W'(XSDLL) : CNT_W'(XPDLL_CYC);
   // Only a self-refresh with a floated reference holds writes off.
   assign write_wait_done = !from_sr || !vref_floated
      || (since_exit >= CNT_W'(VREF_FLOAT_CYC));

   // One controller FSM; timers are counted in cnt and since_exit.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= LPC_RUN;
         cnt <= '0;
         since_exit <= CNT_W'(XSDLL);
         need_ref <= 1'b0;
         from_sr <= 1'b0;
         link.cke <= 1'b1;
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
         link.odt <= 1'b0;
         link.reset_n <= 1'b1;
         busy <= 1'b0;
         nondll_ok <= 1'b1;
         locked_ok <= 1'b1;
         write_ok <= 1'b1;
      end
      else
      begin
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
         if (since_exit != 16'hFFFF)
         begin
            since_exit <= since_exit + 1'b1;
         end
         cnt <= (cnt != '0) ? cnt - 1'b1 : cnt;
         case (state)
            LPC_RUN:
            begin
               busy <= 1'b0;
               if (sr_req && banks_idle && since_exit >= CNT_W'(XS_CYC))
               begin
                  busy <= 1'b1;
                  link.odt <= 1'b0;
                  cnt <= CNT_W'(ODT_LEAD_CYC);
                  state <= need_ref ? LPC_REF : LPC_ODT_OFF;
               end
               else if (pd_req && since_exit >= CNT_W'(XPDLL_CYC))
               begin
                  busy <= 1'b1;
                  link.cke <= 1'b0;
                  cnt <= CNT_W'(AREFI_CYC * PD_MAX_REFI);
                  state <= LPC_IN_PD;
               end
            end
            LPC_REF:
            begin
               // Extra refresh, then its full cycle time before entry.
               {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
               need_ref <= 1'b0;
               cnt <= CNT_W'(ODT_LEAD_CYC + REF_INT_CYC);
               state <= LPC_ODT_OFF;
            end
            LPC_ODT_OFF:
            begin
               if (cnt == '0)
               begin
                  link.cke <= 1'b0;
                  {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                  cnt <= CNT_W'(SR_RES_CYC);
                  state <= LPC_IN_SR;
               end
            end
            LPC_IN_SR:
            begin
               link.cke <= 1'b0;
               // Clock runs throughout, so stability before exit holds.
               if (cnt == '0 && wake_req)
               begin
                  link.cke <= 1'b1;
                  since_exit <= '0;
                  nondll_ok <= 1'b0;
                  locked_ok <= 1'b0;
                  write_ok <= !vref_floated;
                  from_sr <= 1'b1;
                  need_ref <= 1'b1;
                  state <= LPC_EXIT;
               end
            end
            LPC_IN_PD:
            begin
               link.cke <= 1'b0;
               // Exit on request after the minimum pulse, or at the limit.
               if ((wake_req && cnt <= CNT_W'(AREFI_CYC * PD_MAX_REFI - CKE_MIN_CYC))
                  || cnt == '0)
               begin
                  link.cke <= 1'b1;
                  since_exit <= '0;
                  nondll_ok <= 1'b0;
                  locked_ok <= 1'b0;
                  from_sr <= 1'b0;
                  state <= LPC_EXIT;
               end
            end
            LPC_EXIT:
            begin
               link.cke <= 1'b1;
               link.odt <= 1'b0;
               nondll_ok <= since_exit >= CNT_W'(XS_CYC > XP_CYC ? XS_CYC : XP_CYC);
               locked_ok <= since_exit >= lock_wait;
               write_ok <= write_wait_done;
               if (since_exit >= lock_wait && write_wait_done)
               begin
                  locked_ok <= 1'b1;
                  write_ok <= 1'b1;
                  state <= LPC_RUN;
               end
            end
            default:
            begin
               state <= LPC_RUN;
            end
         endcase
      end
   end
endmodule

`default_nettype wire

/* File: bench/lps_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the link pins and the device state.
module lps_asserts
import lps_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic [2:0] power_state
);
   // No-operation or deselect on the pins.
   wire logic nop = cs_n || ({ras_n, cas_n, we_n} == 3'h7);
   // Refresh encoding on the pins.
   wire logic refc = !cs_n && ({ras_n, cas_n, we_n} == 3'h1);
   logic [15:0] low_cnt; // Edges with CKE low.
   logic [15:0] odt_cnt; // Edges with ODT low.
   logic ref_seen; // Refresh given since the last exit.

   // Counts restart when the signal rises, so an old count never passes.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         low_cnt <= 16'h0000;
         odt_cnt <= 16'h0000;
         ref_seen <= 1'b1;
      end
      else
      begin
         low_cnt <= cke ? 16'h0000 : low_cnt + 16'h0001;
         odt_cnt <= odt ? 16'h0000 : odt_cnt + 16'h0001;
         ref_seen <= (power_state == 3'h3) ? 1'b0 : (ref_seen || (refc && cke));
      end
   end

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Entry command: CKE falls with the refresh encoding.
   sequence sre_s;
      $fell(cke) && refc;
   endsequence
   // Exit: CKE seen high in self-refresh, then the exit state.
   sequence sr_exit_s;
      (power_state == 3'h1 && cke) ##1 power_state == 3'h3;
   endsequence

   sr_entry_a: assert property (sre_s |=> power_state == 3'h1)
      else $error("self-refresh entry not taken");
   sr_exit_a: assert property (power_state == 3'h1 && cke |-> nop ##1 power_state == 3'h3)
      else $error("self-refresh exit wrong");
   exit_nop_a: assert property (sr_exit_s |-> nop [*8])
      else $error("command during exit delay");
   exit_hold_a: assert property (sr_exit_s |-> (cke && !odt) [*8])
      else $error("CKE or ODT wrong after exit");
   pd_entry_a: assert property ($fell(cke) && nop && power_state == 3'h0
      |=> power_state == 3'h2 || power_state == 3'h6)
      else $error("power-down entry not taken");
   pd_exit_a: assert property ((power_state == 3'h2 || power_state == 3'h6) && cke && nop
      |=> power_state == 3'h0)
      else $error("power-down exit not taken");
   cke_min_a: assert property ($rose(cke) |-> low_cnt >= CKE_MIN_CYC)
      else $error("CKE low too short");
   odt_lead_a: assert property (sre_s |-> odt_cnt >= ODT_LEAD_CYC)
      else $error("termination on at entry");
   reentry_ref_a: assert property (sre_s |-> ref_seen)
      else $error("no refresh before re-entry");
   sr_resid_a: assert property (sr_exit_s |-> $past(low_cnt, 1) >= SR_RES_CYC)
      else $error("self-refresh too short");
endmodule

`default_nettype wire

/* File: bench/dram_self_refresh_power_down_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Joins both ends and runs the low-power scenarios.
module dram_self_refresh_power_down_tb_top;
   import lps_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sr_req = 1'b0;
   logic pd_req = 1'b0;
   logic wake_req = 1'b0;
   logic banks_idle = 1'b1;
   logic vref_floated = 1'b1;
   logic any_bank_open = 1'b0;
   logic dll_disable_bit = 1'b0;
   logic slow_fast_exit_select_bit = 1'b0;
   logic [2:0] power_state;
   logic dll_enabled, dll_reset_pulse, internal_clk_on, input_buffers_on;
   logic cmd_receivers_on, internal_refresh_pulse, busy, nondll_ok, locked_ok, write_ok;
   int miscompares = 0;
   int n_compared = 0;

   // Half period of 50 ns gives 10 MHz.
   always #50 ref_clk = ~ref_clk;

   lps_link_if link_if();
   lps_device lps_device_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if.dev),
      .any_bank_open(any_bank_open), .dll_disable_bit(dll_disable_bit),
      .slow_fast_exit_select_bit(slow_fast_exit_select_bit), .power_state(power_state),
      .dll_enabled(dll_enabled), .dll_reset_pulse(dll_reset_pulse),
      .internal_clk_on(internal_clk_on), .input_buffers_on(input_buffers_on),
      .cmd_receivers_on(cmd_receivers_on), .internal_refresh_pulse(internal_refresh_pulse));
   // A short locked-DLL wait keeps the run brief.
   lps_controller #(.XSDLL(20)) lps_controller_inst(.ref_clk(ref_clk), .rst_n(rst_n),
      .link(link_if.ctrl), .sr_req(sr_req), .pd_req(pd_req), .wake_req(wake_req),
      .banks_idle(banks_idle), .vref_floated(vref_floated), .dll_was_unlocked(1'b0),
      .busy(busy), .nondll_ok(nondll_ok), .locked_ok(locked_ok), .write_ok(write_ok));
   lps_asserts lps_asserts_inst(.ref_clk(ref_clk), .rst_n(rst_n), .cke(link_if.cke),
      .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
      .we_n(link_if.we_n), .odt(link_if.odt), .power_state(power_state));

   // Compares and counts.
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task final_report;
      $display("compared=%0d mismatches=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Samples just after the edge so its updates have landed.
   task tick;
      @(posedge ref_clk);
      #1;
   endtask

   // Waits a bounded time for a power state.
   task wait_ps(input logic [2:0] s, input int lim);
      int n;
      n = 0;
      while (power_state !== s && n < lim)
      begin
         tick();
         n++;
      end
      check(16'(power_state), 16'(s));
   endtask

   // Power-down with a bank state and exit mode.
   task t_pd(input logic open, input logic slow);
      int n;
      @(posedge ref_clk);
      any_bank_open <= open;
      banks_idle <= !open;
      slow_fast_exit_select_bit <= !slow;
      pd_req <= 1'b1;
      wait_ps(open ? 3'h6 : 3'h2, 20);
      @(posedge ref_clk);
      pd_req <= 1'b0;
      tick();
      check(16'(dll_enabled), 16'(!(slow && !open)));
      repeat (CPDED_CYC + 2) tick();
      check(16'({input_buffers_on, cmd_receivers_on}), 16'h0000);
      @(posedge ref_clk);
      wake_req <= 1'b1;
      wait_ps(3'h0, 200);
      check(16'(nondll_ok), 16'h0000);
      n = 0;
      while (locked_ok !== 1'b1 && n < 200)
      begin
         tick();
         n++;
      end
      check(16'(n >= XP_CYC - 1), 16'h0001);
      wake_req <= 1'b0;
      $display("power-down test done");
   endtask

   // Self-refresh with the DLL on or off.
   task t_sr(input logic dll_dis);
      int n;
      logic r;
      @(posedge ref_clk);
      dll_disable_bit <= dll_dis;
      any_bank_open <= 1'b0;
      banks_idle <= 1'b1;
      sr_req <= 1'b1;
      wait_ps(3'h1, 80);
      @(posedge ref_clk);
      sr_req <= 1'b0;
      tick();
      check(16'({dll_enabled, internal_clk_on}), 16'h0000);
      n = 0;
      repeat (CKE_MIN_CYC)
      begin
         tick();
         if (internal_refresh_pulse === 1'b1)
            n++;
      end
      check(16'(n != 0), 16'h0001);
      @(posedge ref_clk);
      wake_req <= 1'b1;
      wait_ps(3'h3, 100);
      r = dll_reset_pulse;
      tick();
      r = r | dll_reset_pulse;
      check(16'(r), 16'(!dll_dis));
      wait_ps(3'h0, 10);
      wake_req <= 1'b0;
      n = 0;
      while (write_ok !== 1'b1 && n < 700)
      begin
         tick();
         n++;
      end
      check(16'(n >= VREF_FLOAT_CYC - 2), 16'h0001);
      check(16'(locked_ok), 16'h0001);
      $display("self-refresh test done");
   endtask

   // Main sequence; the second self-refresh is a re-entry.
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      tick();
      t_pd(1'b0, 1'b1);
      t_pd(1'b0, 1'b0);
      t_pd(1'b1, 1'b1);
      t_sr(1'b0);
      t_sr(1'b1);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      tick();
      check(16'(power_state), 16'h0004);
      $display("reset test done");
      final_report();
   end

   // Cuts a hang short after far more than the tests need.
   initial
   begin
      #(100 * 20000);
      miscompares++;
      final_report();
   end
endmodule

`default_nettype wire
